// *** rtl/gdt_top.sv ***
// Purpose: Phase command pipeline, dead interval, blanking, fault filters, serial port.
// Assumes: All pins are asynchronous to mclk_i; serial clock is far slower than mclk_i.
// Notes: Frames are 16 bits, MSB first, opcode in bits 15..12.
// Notes on behaviour
// - All control logic runs on one clock; pins pass synchronisers first.
// - Normal mode: one decision stage, then one full-on multiplexer stage, then gate.
// - Full-on mode skips the decision stage, one clock less latency.
// - Synchroniser adds at most one clock of latency variation.
// - Dead interval adds on top of the fixed pipeline delay.
// - Over-temperature comparator is filtered before warning or interrupt.
// - A dedicated command sets the dead interval to zero.
// - Programmed dead interval counts 1 to 255 time-base cycles.
// - Requests above 255 saturate at 255.
// - Any switch turning on starts common blanking, hiding desat and phase errors.
// - Zero duty holds the switch off; steady command holds it on forever.
// - Gate-permit changes reach gate outputs within 280 ns.
// - Serial input sampled on falling serial clock edge; host sets it up before.
// - Serial output changes after each rising edge but the first, valid within 125 ns.
// - Serial output driven with status within 100 ns of chip select falling.
// - Serial output released within 125 ns of chip select rising.
// - Blanking window lasts 4.7 to 9.1 us, typically 7.1 us.
// - Desaturation reported only after persisting for the 937 ns filter time.
// - Dead timer starts at switch-off; in normal mode it blocks complementary turn-on until expiry.
// - In normal mode command inputs are edge sensitive: complement off now, selected on later.
`timescale 1ns/1ps
module gdt_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Phase commands and gate permits
  input wire logic [gdt_pkg::NPHASE-1:0] high_side_command_input_i,
  input wire logic [gdt_pkg::NPHASE-1:0] low_side_command_input_i,
  input wire logic gate_permit_a_i,
  input wire logic gate_permit_b_i,
  // Raw comparator inputs
  input wire logic [gdt_pkg::NPHASE-1:0] desat_raw_i,
  input wire logic [gdt_pkg::NPHASE-1:0] phase_err_raw_i,
  input wire logic over_temp_raw_i,
  // Serial port
  input wire logic spi_sclk_i,
  input wire logic spi_cs_b_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_b_o,
  // Gate outputs
  output logic [gdt_pkg::NPHASE-1:0] hs_gate_o,
  output logic [gdt_pkg::NPHASE-1:0] ls_gate_o,
  // Status
  output logic full_on_mode_o,
  output logic zero_dead_o,
  output logic [gdt_pkg::DEAD_W-1:0] dead_cycles_o,
  output logic blanking_o,
  output logic [gdt_pkg::NPHASE-1:0] desat_fault_o,
  output logic [gdt_pkg::NPHASE-1:0] phase_fault_o,
  output logic temp_warn_o,
  output logic int_o
);
  import gdt_pkg::*;

  // Pin vector layout
  localparam int P_HS = 0;
  localparam int P_LS = 3;
  localparam int P_PA = 6;
  localparam int P_PB = 7;
  localparam int P_DS = 8;
  localparam int P_PE = 11;
  localparam int P_OT = 14;
  localparam int P_SCK = 15;
  localparam int P_CS = 16;
  localparam int P_SI = 17;
  localparam int NPIN = 18;
  localparam logic [NPIN-1:0] PIN_RST = 18'h10000;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Clamp a requested dead interval into 1..255
  function automatic logic [DEAD_W-1:0] clamp_dead(input logic [ARG_W-1:0] req);
    logic [DEAD_W-1:0] res;
    res = req[DEAD_W-1:0];
    if (req > ARG_W'(DEAD_MAX))
      res = DEAD_MAX;
    else if (req < ARG_W'(DEAD_MIN))
      res = DEAD_MIN;
    return res;
  endfunction

  // Reset release
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin;
  wire [NPIN-1:0] next_pin = (pin_s2 & pin_s3) | (pin & (pin_s2 ^ pin_s3));

  assign pin_raw = {spi_si_i, spi_cs_b_i, spi_sclk_i, over_temp_raw_i, phase_err_raw_i,
                    desat_raw_i, gate_permit_b_i, gate_permit_a_i,
                    low_side_command_input_i, high_side_command_input_i};

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
      pin_s3 <= PIN_RST;
      pin <= PIN_RST;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin <= next_pin;
    end
  end

  wire [NPHASE-1:0] hs_lvl = pin[P_HS +: NPHASE];
  wire [NPHASE-1:0] ls_lvl = pin[P_LS +: NPHASE];
  wire permit = pin[P_PA] & pin[P_PB];

  // Configuration held from serial commands
  logic [DEAD_W-1:0] dead_cycles;
  logic zero_dead;
  logic full_on;
  logic full_on_locked;
  logic blanking;

  // Per-phase decision stage
  logic [NPHASE-1:0] hs_prev;
  logic [NPHASE-1:0] ls_prev;
  logic [NPHASE-1:0] dec_hs;
  logic [NPHASE-1:0] dec_ls;
  logic [NPHASE-1:0] next_dec_hs;
  logic [NPHASE-1:0] next_dec_ls;
  logic [NPHASE-1:0] hs_gate;
  logic [NPHASE-1:0] ls_gate;
  logic [NPHASE-1:0] next_hs_gate;
  logic [NPHASE-1:0] next_ls_gate;
  wire [DEAD_W-1:0] dead_load = zero_dead ? DEAD_ZERO : dead_cycles;

  for (genvar p = 0; p < NPHASE; p++)
  begin : g_phase
    gdt_owner_t owner;
    gdt_owner_t next_owner;
    logic [DEAD_W-1:0] dead_cnt;
    wire hs_edge = rise(hs_lvl[p], hs_prev[p]);
    wire ls_edge = rise(ls_lvl[p], ls_prev[p]);
    wire want_hs = (next_owner == GDT_OWN_HS);
    wire want_ls = (next_owner == GDT_OWN_LS);
    wire off_evt = (dec_hs[p] & ~want_hs) | (dec_ls[p] & ~want_ls);
    // Expiry flagged as the count reaches one, so the gap is exactly D cycles
    wire dead_done = (dead_cnt <= DEAD_MIN) & (~off_evt | zero_dead);

    // Leading edges pick the side; a dropped level returns to off
    always_comb
    begin
      next_owner = owner;
      unique case (owner)
        GDT_OWN_NONE:
        begin
          if (hs_edge && !ls_edge)
            next_owner = GDT_OWN_HS;
          else if (ls_edge && !hs_edge)
            next_owner = GDT_OWN_LS;
        end
        GDT_OWN_HS:
        begin
          if (ls_edge)
            next_owner = GDT_OWN_LS;
          else if (!hs_lvl[p])
            next_owner = GDT_OWN_NONE;
        end
        GDT_OWN_LS:
        begin
          if (hs_edge)
            next_owner = GDT_OWN_HS;
          else if (!ls_lvl[p])
            next_owner = GDT_OWN_NONE;
        end
        default:
          next_owner = GDT_OWN_NONE;
      endcase
    end

    // Turn-on waits for expiry; an already-on switch stays on
    assign next_dec_hs[p] = want_hs & (dec_hs[p] | dead_done);
    assign next_dec_ls[p] = want_ls & (dec_ls[p] | dead_done);

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        owner <= GDT_OWN_NONE;
        dead_cnt <= DEAD_ZERO;
      end
      else
      begin
        owner <= next_owner;
        if (off_evt)
          dead_cnt <= dead_load;
        else if (dead_cnt != DEAD_ZERO)
          dead_cnt <= dead_cnt - 1'b1;
      end
    end
  end

  // Full-on multiplexer stage, gated by both permits
  assign next_hs_gate = (full_on ? hs_lvl : dec_hs) & {NPHASE{permit}};
  assign next_ls_gate = (full_on ? ls_lvl : dec_ls) & {NPHASE{permit}};

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hs_prev <= '0;
      ls_prev <= '0;
      dec_hs <= '0;
      dec_ls <= '0;
      hs_gate <= '0;
      ls_gate <= '0;
    end
    else
    begin
      hs_prev <= hs_lvl;
      ls_prev <= ls_lvl;
      dec_hs <= next_dec_hs;
      dec_ls <= next_dec_ls;
      hs_gate <= next_hs_gate;
      ls_gate <= next_ls_gate;
    end
  end

  assign hs_gate_o = hs_gate;
  assign ls_gate_o = ls_gate;

  // Common blanking, restarted by any switch turning on
  localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYC);
  logic [BLANK_W-1:0] blank_cnt;
  wire turn_on = |((next_hs_gate & ~hs_gate) | (next_ls_gate & ~ls_gate));

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      blank_cnt <= '0;
    else if (turn_on)
      blank_cnt <= BLANK_LOAD;
    else if (blank_cnt != '0)
      blank_cnt <= blank_cnt - 1'b1;
  end

  assign blanking = (blank_cnt != '0);
  assign blanking_o = blanking;

  // Fault filters
  localparam logic [FILT_W-1:0] DESAT_LIMIT = FILT_W'(DESAT_FILT_CYC);
  localparam logic [FILT_W-1:0] TEMP_LIMIT = FILT_W'(TEMP_FILT_CYC);
  logic [NPHASE-1:0] desat_hit;
  logic temp_hit;

  for (genvar p = 0; p < NPHASE; p++)
  begin : g_desat
    gdt_filter #(
      .WIDTH(FILT_W),
      .LIMIT(DESAT_LIMIT)
    ) u_desat_filt (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .raw_i(pin[P_DS + p]),
      .hit_o(desat_hit[p])
    );
  end

  gdt_filter #(
    .WIDTH(FILT_W),
    .LIMIT(TEMP_LIMIT)
  ) u_temp_filt (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .raw_i(pin[P_OT]),
    .hit_o(temp_hit)
  );

  // Serial port
  gdt_spi_st_t spi_st;
  logic sclk_prev;
  logic cs_prev;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [BITCNT_W-1:0] bit_cnt;
  logic so_oe_b;
  logic cmd_valid;
  logic [FRAME_BITS-1:0] cmd_word;
  wire sclk_rise = rise(pin[P_SCK], sclk_prev);
  wire sclk_fall = rise(sclk_prev, pin[P_SCK]);
  wire cs_fall = rise(cs_prev, pin[P_CS]);
  wire cs_rise = rise(pin[P_CS], cs_prev);
  wire frame_full = (bit_cnt == BITCNT_W'(FRAME_BITS));
  logic [FRAME_BITS-1:0] status_word;
  logic [NPHASE-1:0] desat_fault;
  logic [NPHASE-1:0] phase_fault;
  logic temp_warn;

  assign status_word = {temp_warn, phase_fault, desat_fault, full_on, dead_cycles};

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spi_st <= GDT_SPI_IDLE;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
      shift_in <= '0;
      shift_out <= '0;
      bit_cnt <= '0;
      so_oe_b <= 1'b1;
      cmd_valid <= 1'b0;
      cmd_word <= '0;
    end
    else
    begin
      sclk_prev <= pin[P_SCK];
      cs_prev <= pin[P_CS];
      cmd_valid <= 1'b0;
      unique case (spi_st)
        GDT_SPI_IDLE:
        begin
          if (cs_fall)
          begin
            spi_st <= GDT_SPI_FRAME;
            shift_out <= status_word;
            so_oe_b <= 1'b0;
            bit_cnt <= '0;
          end
        end
        GDT_SPI_FRAME:
        begin
          if (cs_rise)
          begin
            spi_st <= GDT_SPI_IDLE;
            so_oe_b <= 1'b1;
            shift_out <= '0;
            cmd_valid <= frame_full;
            cmd_word <= shift_in;
          end
          else if (sclk_fall)
          begin
            shift_in <= {shift_in[FRAME_BITS-2:0], pin[P_SI]};
            if (!frame_full)
              bit_cnt <= bit_cnt + 1'b1;
          end
          else if (sclk_rise && bit_cnt != '0)
            shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
        end
      endcase
    end
  end

  assign spi_so_o = shift_out[FRAME_BITS-1];
  assign spi_so_oe_b_o = so_oe_b;

  // Command decode
  wire [3:0] opc = cmd_word[OPC_MSB:OPC_LSB];
  wire [ARG_W-1:0] arg = cmd_word[ARG_MSB:0];
  wire do_set_dead = cmd_valid & (opc == OPC_SET_DEAD);
  wire do_zero_dead = cmd_valid & (opc == OPC_ZERO_DEAD);
  wire do_full_on = cmd_valid & (opc == OPC_FULL_ON) & ~full_on_locked;
  wire do_clear = cmd_valid & (opc == OPC_CLR_FAULT);

  // Full-on may be chosen once per reset, to avoid accidental overlap
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dead_cycles <= DEAD_RST;
      zero_dead <= 1'b0;
      full_on <= 1'b0;
      full_on_locked <= 1'b0;
    end
    else
    begin
      if (do_set_dead)
      begin
        dead_cycles <= clamp_dead(arg);
        zero_dead <= 1'b0;
      end
      else if (do_zero_dead)
        zero_dead <= 1'b1;
      if (do_full_on)
      begin
        full_on <= arg[0];
        full_on_locked <= 1'b1;
      end
    end
  end

  // Sticky faults; a new fault wins over a clear in the same cycle
  wire [NPHASE-1:0] desat_set = desat_hit & {NPHASE{~blanking}};
  wire [NPHASE-1:0] phase_set = pin[P_PE +: NPHASE] & {NPHASE{~blanking}};

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      desat_fault <= '0;
      phase_fault <= '0;
      temp_warn <= 1'b0;
      int_o <= 1'b0;
    end
    else
    begin
      desat_fault <= (desat_fault & {NPHASE{~do_clear}}) | desat_set;
      phase_fault <= (phase_fault & {NPHASE{~do_clear}}) | phase_set;
      temp_warn <= (temp_warn & ~do_clear) | temp_hit;
      int_o <= |desat_fault | |phase_fault | temp_warn;
    end
  end

  assign desat_fault_o = desat_fault;
  assign phase_fault_o = phase_fault;
  assign temp_warn_o = temp_warn;
  assign full_on_mode_o = full_on;
  assign zero_dead_o = zero_dead;
  assign dead_cycles_o = dead_cycles;

endmodule

// *** rtl/gdt_pkg.sv ***
// Purpose: Shared constants and types of the gate drive timing control.
// Assumes: Core clock of 200 MHz, which also serves as the dead-interval time base.
// Notes: Times are kept in their own unit, and cycle counts are derived from them.
package gdt_pkg;

  // Clock and derived timing
  localparam int CLK_PERIOD_PS = 5000;
  // Blanking window: least 4.7 us, most 9.1 us; the typical value is used
  localparam int BLANK_TYP_NS = 7100;
  localparam int BLANK_CYC = (BLANK_TYP_NS * 1000) / CLK_PERIOD_PS;
  localparam int DESAT_FILT_NS = 937;
  localparam int DESAT_FILT_CYC = (DESAT_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TEMP_FILT_NS = 1000;
  localparam int TEMP_FILT_CYC = (TEMP_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Widths
  localparam int NPHASE = 3;
  localparam int DEAD_W = 8;
  localparam int BLANK_W = 11;
  localparam int FILT_W = 8;
  localparam int FRAME_BITS = 16;
  localparam int BITCNT_W = 5;

  // Dead interval limits and reset value
  localparam logic [DEAD_W-1:0] DEAD_MIN = 8'h01;
  localparam logic [DEAD_W-1:0] DEAD_MAX = 8'hff;
  localparam logic [DEAD_W-1:0] DEAD_RST = 8'h10;
  localparam logic [DEAD_W-1:0] DEAD_ZERO = 8'h00;

  // Serial frame layout: opcode on top, argument below
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int ARG_MSB = 11;
  localparam int ARG_W = 12;
  localparam logic [3:0] OPC_SET_DEAD = 4'h1;
  localparam logic [3:0] OPC_ZERO_DEAD = 4'h2;
  localparam logic [3:0] OPC_FULL_ON = 4'h3;
  localparam logic [3:0] OPC_CLR_FAULT = 4'h4;

  // Status word returned on every frame
  localparam int ST_TEMP = 15;
  localparam int ST_PHASE_LSB = 12;
  localparam int ST_DESAT_LSB = 9;
  localparam int ST_FULL_ON = 8;

  // Per-phase command owner, the decision state
  typedef enum logic [1:0] {
    GDT_OWN_NONE = 2'b00,
    GDT_OWN_HS = 2'b01,
    GDT_OWN_LS = 2'b10
  } gdt_owner_t;

  typedef enum logic {
    GDT_SPI_IDLE = 1'b0,
    GDT_SPI_FRAME = 1'b1
  } gdt_spi_st_t;

endpackage

// *** rtl/gdt_filter.sv ***
// Purpose: Digital persistence filter for one raw comparator input.
// Assumes: Raw input is already synchronised to mclk_i.
// Notes: Output is high once the input has held high for LIMIT cycles.
`timescale 1ns/1ps
module gdt_filter #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] LIMIT = 8'hbc
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw level and filtered result
  input wire logic raw_i,
  output logic hit_o
);

  logic [WIDTH-1:0] cnt;

  // Saturating, cleared by any drop of the raw input
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= '0;
    else if (!raw_i)
      cnt <= '0;
    else if (cnt != LIMIT)
      cnt <= cnt + 1'b1;
  end

  assign hit_o = (cnt == LIMIT);

endmodule

// *** tb/gdt_chk.sv ***
// Purpose: Port assertions for the gate drive timing top.
// Assumes: One clock domain; sees top ports only.
// Notes: Small run counters stand in for long repetitions.
`timescale 1ns/1ps
module gdt_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Watched inputs
  input wire logic gate_permit_a_i,
  input wire logic gate_permit_b_i,
  input wire logic [gdt_pkg::NPHASE-1:0] desat_raw_i,
  input wire logic over_temp_raw_i,
  input wire logic spi_cs_b_i,
  // Watched outputs
  input wire logic spi_so_oe_b_o,
  input wire logic [gdt_pkg::NPHASE-1:0] hs_gate_o,
  input wire logic [gdt_pkg::NPHASE-1:0] ls_gate_o,
  input wire logic full_on_mode_o,
  input wire logic [gdt_pkg::DEAD_W-1:0] dead_cycles_o,
  input wire logic blanking_o,
  input wire logic [gdt_pkg::NPHASE-1:0] desat_fault_o,
  input wire logic [gdt_pkg::NPHASE-1:0] phase_fault_o,
  input wire logic temp_warn_o,
  input wire logic int_o
);
  import gdt_pkg::*;
  logic [8:0] hot_cnt;
  logic [8:0] des_cnt;
  logic [11:0] blank_run;
  logic [5:0] perm_cnt;
  logic [4:0] cs_hi_cnt;
  logic [4:0] cs_lo_cnt;

  // Saturating run lengths; raw pins lead the synced copies, so counts are upper bounds
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hot_cnt <= 9'h000;
      des_cnt <= 9'h000;
      blank_run <= 12'h000;
      perm_cnt <= 6'h00;
      cs_hi_cnt <= 5'h00;
      cs_lo_cnt <= 5'h00;
    end
    else
    begin
      hot_cnt <= over_temp_raw_i ? hot_cnt + 9'(~&hot_cnt) : 9'h000;
      des_cnt <= desat_raw_i[0] ? des_cnt + 9'(~&des_cnt) : 9'h000;
      blank_run <= blanking_o ? blank_run + 12'(~&blank_run) : 12'h000;
      perm_cnt <= (gate_permit_a_i && gate_permit_b_i) ? 6'h00 : perm_cnt + 6'(~&perm_cnt);
      cs_hi_cnt <= spi_cs_b_i ? cs_hi_cnt + 5'(~&cs_hi_cnt) : 5'h00;
      cs_lo_cnt <= spi_cs_b_i ? 5'h00 : cs_lo_cnt + 5'(~&cs_lo_cnt);
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_TEMP_FILT: assert property ($rose(temp_warn_o) |-> hot_cnt >= 9'h0c8)
    else $error("temperature warning before filter time");
  AST_INT_FOLLOW: assert property (int_o == $past(temp_warn_o || (|desat_fault_o) || (|phase_fault_o)))
    else $error("interrupt does not follow flags");
  AST_DESAT_FILT: assert property ($rose(desat_fault_o[0]) |-> des_cnt >= 9'h0bc)
    else $error("desat flag before filter time");
  AST_DESAT_BLANK: assert property ($rose(desat_fault_o[0]) |-> !$past(blanking_o))
    else $error("desat flag during blanking");
  AST_PHASE_BLANK: assert property (|(phase_fault_o & ~$past(phase_fault_o))
    |-> !$past(blanking_o))
    else $error("phase flag during blanking");
  AST_BLANK_START: assert property ((|(hs_gate_o & ~$past(hs_gate_o))) || (|(ls_gate_o & ~$past(ls_gate_o))) |-> ##[0:1] blanking_o)
    else $error("gate on without blanking");
  AST_BLANK_LEN: assert property ($fell(blanking_o) |-> blank_run >= 12'h3ac)
    else $error("blanking window too short");
  AST_PERMIT_OFF: assert property (perm_cnt >= 6'h38 |-> !(|hs_gate_o) && !(|ls_gate_o))
    else $error("gate on without permit");
  AST_SO_ENABLE: assert property (cs_lo_cnt >= 5'h14 |-> !spi_so_oe_b_o)
    else $error("serial output not driven");
  AST_SO_RELEASE: assert property (cs_hi_cnt >= 5'h19 |-> spi_so_oe_b_o)
    else $error("serial output not released");
  AST_NO_OVERLAP: assert property (!full_on_mode_o |-> !(|(hs_gate_o & ls_gate_o)))
    else $error("both gates on in normal mode");
  AST_DEAD_RANGE: assert property (dead_cycles_o != 8'h00)
    else $error("dead count out of range");
endmodule

bind gdt_top gdt_chk gdt_chk_i (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .gate_permit_a_i(gate_permit_a_i),
  .gate_permit_b_i(gate_permit_b_i), .desat_raw_i(desat_raw_i),
  .over_temp_raw_i(over_temp_raw_i), .spi_cs_b_i(spi_cs_b_i), .spi_so_oe_b_o(spi_so_oe_b_o),
  .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o), .full_on_mode_o(full_on_mode_o),
  .dead_cycles_o(dead_cycles_o), .blanking_o(blanking_o), .desat_fault_o(desat_fault_o),
  .phase_fault_o(phase_fault_o), .temp_warn_o(temp_warn_o), .int_o(int_o)
);

// *** tb/gdt_host.sv ***
// Purpose: Host model framing the serial port of the gate drive block.
// Assumes: Serial clock idles low, 125 ns period; 16-bit words, MSB first.
// Notes: Data line shows the inverse of its last bit once released.
`timescale 1ns/1ps
module gdt_host (
  // Serial lines driven
  output logic sclk_o,
  output logic cs_b_o,
  output logic si_o,
  // Serial return
  input wire logic so_i,
  input wire logic so_oe_b_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b1;
  end

  // Returns the word read back and whether SO came on and went off in time
  task automatic frame(input logic [15:0] word, output logic [15:0] rd, output logic en,
    output logic dis);
    rd = 16'h0000;
    cs_b_o = 1'b0;
    #100;
    en = !so_oe_b_i;
    // Twice the host's rate limit on purpose, to stress pin sampling
    for (int i = 15; i >= 0; i--)
    begin
      si_o = word[i];
      sclk_o = 1'b1;
      #62.5;
      rd = {rd[14:0], so_i};
      sclk_o = 1'b0;
      #62.5;
    end
    #100;
    cs_b_o = 1'b1;
    si_o = !si_o;
    #125;
    dis = so_oe_b_i;
    #100;
  endtask
endmodule

// *** tb/gdt_top_tb.sv ***
// Purpose: Self-checking bench for the gate drive timing top.
// Assumes: 200 MHz core clock; the host model frames the serial port.
// Notes: Full-on runs last, since only a reset leaves it.
`timescale 1ns/1ps
module gdt_top_tb;
  import gdt_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic perm_a = 1'b1;
  logic perm_b = 1'b1;
  logic otemp = 1'b0;
  logic [NPHASE-1:0] hs_cmd = '0;
  logic [NPHASE-1:0] ls_cmd = '0;
  logic [NPHASE-1:0] desat = '0;
  logic [NPHASE-1:0] perr = '0;
  logic sclk, cs_b, si, so, so_oe_b, full_on, zero_dead, blank, temp_w, irq, en, dis;
  logic [NPHASE-1:0] hs_gate, ls_gate, desat_f, phase_f;
  logic [DEAD_W-1:0] dead;
  logic [15:0] rd;
  int n;
  int miscompares = 0;
  int checked = 0;

  gdt_top gdt_top_i (
    .mclk_i(mclk), .rst_b_i(rst_b), .high_side_command_input_i(hs_cmd),
    .low_side_command_input_i(ls_cmd), .gate_permit_a_i(perm_a), .gate_permit_b_i(perm_b),
    .desat_raw_i(desat), .phase_err_raw_i(perr), .over_temp_raw_i(otemp), .spi_sclk_i(sclk),
    .spi_cs_b_i(cs_b), .spi_si_i(si), .spi_so_o(so), .spi_so_oe_b_o(so_oe_b),
    .hs_gate_o(hs_gate), .ls_gate_o(ls_gate), .full_on_mode_o(full_on),
    .zero_dead_o(zero_dead), .dead_cycles_o(dead), .blanking_o(blank),
    .desat_fault_o(desat_f), .phase_fault_o(phase_f), .temp_warn_o(temp_w), .int_o(irq)
  );
  gdt_host gdt_host_i (
    .sclk_o(sclk), .cs_b_o(cs_b), .si_o(si), .so_i(so), .so_oe_b_i(so_oe_b)
  );

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Leaves time just after a rising edge, where inputs may change safely
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic send(input logic [15:0] w);
    gdt_host_i.frame(w, rd, en, dis);
    tick(2);
  endtask

  // Edges until the output reaches val; sel 0 high gate, 1 low gate, 2 blanking
  task automatic await(input int sel, input int ph, input logic val);
    n = 0;
    while ((sel == 2 ? blank : (sel == 1 ? ls_gate[ph] : hs_gate[ph])) !== val)
    begin
      n++;
      if (n > 2000)
      begin
        miscompares++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
      end
      else
        tick(1);
    end
  endtask

  task automatic t_pipeline(input logic [7:0] d);
    send(d == 8'h00 ? {OPC_ZERO_DEAD, 12'h000} : {OPC_SET_DEAD, 4'h0, d});
    check(16'({zero_dead, dead}), d == 8'h00 ? 16'h01ff : 16'(d), "dead set");
    hs_cmd[0] = 1'b1;
    await(0, 0, 1'b1);
    check(16'(n >= 6 && n <= 7), 16'h0001, "normal latency");
    check(16'(blank), 16'h0001, "blank start");
    ls_cmd[0] = 1'b1;
    await(0, 0, 1'b0);
    await(1, 0, 1'b1);
    check(16'(n), 16'(d), "dead gap");
    check(16'(hs_gate[0]), 16'h0000, "complement off");
    ls_cmd[0] = 1'b0;
    hs_cmd[0] = 1'b0;
    tick(20);
    check(16'({hs_gate, ls_gate}), 16'h0000, "zero duty");
  endtask

  task automatic t_permit();
    for (int k = 0; k < 2; k++)
    begin
      hs_cmd[1] = 1'b1;
      await(0, 1, 1'b1);
      tick(400);
      check(16'(hs_gate[1]), 16'h0001, "steady on");
      perm_a = (k != 0);
      perm_b = (k == 0);
      await(0, 1, 1'b0);
      check(16'(n <= 56), 16'h0001, "permit delay");
      tick(60);
      perm_a = 1'b1;
      perm_b = 1'b1;
      hs_cmd[1] = 1'b0;
      tick(20);
    end
  endtask

  task automatic t_faults();
    hs_cmd[2] = 1'b1;
    await(0, 2, 1'b1);
    desat[0] = 1'b1;
    perr[0] = 1'b1;
    tick(300);
    desat[0] = 1'b0;
    perr[0] = 1'b0;
    await(2, 0, 1'b0);
    check(16'(n + 300 >= 940 && n + 300 <= 1820), 16'h0001, "blank length");
    check(16'({desat_f, phase_f}), 16'h0000, "blanked faults");
    desat[0] = 1'b1;
    tick(150);
    desat[0] = 1'b0;
    tick(10);
    check(16'(desat_f), 16'h0000, "short desat");
    desat[0] = 1'b1;
    tick(200);
    desat[0] = 1'b0;
    perr[1] = 1'b1;
    otemp = 1'b1;
    tick(150);
    otemp = 1'b0;
    perr[1] = 1'b0;
    tick(10);
    check(16'({desat_f, phase_f, temp_w}), 16'h0014, "fault flags");
    otemp = 1'b1;
    tick(220);
    check(16'({temp_w, irq}), 16'h0003, "temp warn");
    otemp = 1'b0;
    hs_cmd[2] = 1'b0;
    send({OPC_CLR_FAULT, 12'h000});
    check(rd, 16'ha205, "status word");
    check(16'({desat_f, phase_f, temp_w, irq}), 16'h0000, "flags cleared");
  endtask

  task automatic t_limits();
    send({OPC_SET_DEAD, 12'h000});
    check(16'(dead), 16'(DEAD_MIN), "dead floor");
    check(rd, 16'h0010, "first status");
    check(16'({en, dis}), 16'h0003, "so on and off");
    send({OPC_SET_DEAD, 12'hfff});
    check(16'(dead), 16'(DEAD_MAX), "dead ceiling");
    check(rd, 16'(DEAD_MIN), "status dead");
  endtask

  // Second full-on request is ignored, so the mode stays set
  task automatic t_full_on();
    send({OPC_FULL_ON, 12'h001});
    send({OPC_FULL_ON, 12'h000});
    hs_cmd[0] = 1'b1;
    await(0, 0, 1'b1);
    check(16'({full_on, n >= 5 && n <= 6}), 16'h0003, "full-on latency");
    hs_cmd[0] = 1'b0;
    rst_b = 1'b0;
    tick(3);
    check(16'({full_on, hs_gate, dead}), 16'h0010, "second reset");
    rst_b = 1'b1;
    tick(4);
  endtask

  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    tick(10);
    check(16'({zero_dead, full_on, so_oe_b, dead}), 16'h0110, "reset modes");
    check(16'({hs_gate, ls_gate, desat_f, phase_f, temp_w, irq}), 16'h0000, "reset gates");
    t_limits();
    t_pipeline(8'h00);
    t_pipeline(8'h05);
    t_permit();
    t_faults();
    t_full_on();
    conclude();
  end
endmodule
